// *** src/avsrc_slave.sv ***
// Purpose: adaptive voltage serial slave with per-rail target voltage and slew registers
// Assumes: link pins asynchronous; pmbus-side inputs come from logic on sys_clk_i
// Notes: link clock is oversampled, so the usable link rate is far below sys_clk_i/4
`timescale 1ns/100ps

// Overview of operation
// - link clock comes from the master, up to 50 MHz; here limited by oversampling.
// - reads served with control on or off, except code 4 and non-version broadcast reads; writes refused unless serial control is selected.
// - command codes 0,1,2,3,4,E,F decoded; others refused.
// - rail 0 and 1 addressed singly, F addresses both rails.
// - reply: ack, zero, 5 status, 16 data, five ones, 3 crc.
// - ack 00 when acted on, 01 when accepted without action.
// - ack 10 and no action when the received crc is wrong.
// - ack 11 and no action for an invalid request.
// - status bit 4 shows the output reached its target.
// - status bit 3 shows a non-done status bit has been set.
// - status bit 2 shows serial control enabled; bits 1:0 zero.
// - reply data all ones for writes and refused reads, addressed value for accepted reads.
// - 16-bit signed target voltage per rail in millivolts, read/write.
// - target loaded from the pmbus output command when control is not selected.
// - target clamped between pmbus minimum and maximum output settings.
// - 16-bit slew word per rail: rise in upper byte, fall lower.
// - slew seeded from pmbus setting and kept until written serially.
// - voltage reset with zero data restores target to pmbus command.
// - data line held low to alert master when a status bit sets.
// - status word: done in bit 15, overtemp warning in bit 12.
module avsrc_slave (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic avs_clk_i,
  input wire logic avs_mdata_i,
  output logic avs_sdata_o,
  input wire logic avs_control_en_i,
  input wire logic [1:0][15:0] vout_command_i,
  input wire logic [1:0][15:0] vout_min_i,
  input wire logic [1:0][15:0] vout_max_i,
  input wire logic [15:0] slew_init_i,
  input wire logic [1:0][15:0] rail_current_i,
  input wire logic [1:0][15:0] temperature_i,
  input wire logic [1:0] voltage_reached_i,
  input wire logic [1:0] overtemp_warning_i,
  output logic [1:0][15:0] target_voltage_o,
  output logic [1:0][15:0] rail_slew_rates_o
);

  // ************************************************************
  // types and state
  // ************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CMD = 4'h2,
    ST_EVAL = 4'h4,
    ST_RESP = 4'h8
  } avsrc_state_t;

  avsrc_state_t st_reg, st_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [31:0] rx_reg, rx_next;
  logic [31:0] tx_reg, tx_next;
  logic sdata_reg, sdata_next;
  logic clk_d_reg;
  logic [1:0] pins_s;
  logic clk_s, md_s, rise, fall;

  logic [1:0][15:0] tgt_reg, tgt_next;
  logic [1:0][15:0] slew_reg, slew_next;
  logic init_reg;
  logic [1:0] vr_d_reg, ot_d_reg, ot_seen_reg, ot_seen_next;
  logic alert_reg, alert_next;

  // decode
  logic [1:0] f_start, f_rw, ack;
  logic f_type, crc_ok, exec, is_write, rail_ok, cmd_ok, write_ok, read_ok;
  logic [3:0] f_cmd, f_rail;
  logic [15:0] f_data, rd_data;
  logic [1:0] sel;
  logic [2:0] rx_crc, tx_crc;
  logic [4:0] stat_resp;
  logic [28:0] resp_body;
  logic any_rise, acted;

  // ************************************************************
  // link pin sampling
  // ************************************************************
  // link clock is a plain sampled input, so its rate is bounded by the sync delay
  avsrc_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({avs_clk_i, avs_mdata_i}),
    .sync_o(pins_s)
  );

  assign clk_s = pins_s[1];
  assign md_s = pins_s[0];
  assign rise = clk_s & ~clk_d_reg;
  assign fall = ~clk_s & clk_d_reg;

  // ************************************************************
  // command decode and reply build
  // ************************************************************
  assign f_start = rx_reg[avsrc_pkg::START_HI -: 2];
  assign f_rw = rx_reg[avsrc_pkg::RW_HI -: 2];
  assign f_type = rx_reg[avsrc_pkg::TYPE_POS];
  assign f_cmd = rx_reg[avsrc_pkg::CMD_HI -: 4];
  assign f_rail = rx_reg[avsrc_pkg::RAIL_HI -: 4];
  assign f_data = rx_reg[avsrc_pkg::DATA_HI -: 16];
  assign is_write = (f_rw == avsrc_pkg::RW_WRITE);
  assign exec = (st_reg == ST_EVAL);

  avsrc_crc3 u_rx_crc (
    .body_i(rx_reg[31:3]),
    .crc_o(rx_crc)
  );
  assign crc_ok = (rx_crc == rx_reg[avsrc_pkg::CRC_HI:0]);

  // rail select: 0, 1 or both
  always_comb
  begin
    sel = 2'b00;
    rail_ok = 1'b1;
    if (f_rail == avsrc_pkg::RAIL_0)
      sel = 2'b01;
    else if (f_rail == avsrc_pkg::RAIL_1)
      sel = 2'b10;
    else if (f_rail == avsrc_pkg::RAIL_ALL)
      sel = 2'b11;
    else
      rail_ok = 1'b0;
  end

  // legality per command; a broadcast read has no single value, so it is refused except for the version code
  always_comb
  begin
    cmd_ok = 1'b1;
    write_ok = 1'b0;
    read_ok = (sel != 2'b11);
    unique case (f_cmd)
      avsrc_pkg::CMD_TARGET: write_ok = 1'b1;
      avsrc_pkg::CMD_SLEW: write_ok = 1'b1;
      avsrc_pkg::CMD_STATUS: write_ok = 1'b1;
      avsrc_pkg::CMD_VRESET:
      begin
        write_ok = 1'b1;
        read_ok = 1'b0;
      end
      avsrc_pkg::CMD_CURRENT, avsrc_pkg::CMD_TEMP: write_ok = 1'b0;
      avsrc_pkg::CMD_VERSION: read_ok = 1'b1;
      default: cmd_ok = 1'b0;
    endcase
  end

  // ack priority: bad crc, then invalid, then accepted
  always_comb
  begin
    if (!crc_ok)
      ack = avsrc_pkg::ACK_BAD_CRC;
    else if (f_start != avsrc_pkg::START_CODE || f_type != avsrc_pkg::CMD_TYPE_STD
             || !rail_ok || !cmd_ok)
      ack = avsrc_pkg::ACK_INVALID;
    else if (is_write)
    begin
      if (!avs_control_en_i || !write_ok)
        ack = avsrc_pkg::ACK_INVALID;
      else if (f_cmd == avsrc_pkg::CMD_VRESET && f_data != avsrc_pkg::VRESET_DATA)
        ack = avsrc_pkg::ACK_NO_ACTION;
      else
        ack = avsrc_pkg::ACK_DONE;
    end
    else if (f_rw == avsrc_pkg::RW_READ && read_ok)
      ack = avsrc_pkg::ACK_DONE;
    else
      ack = avsrc_pkg::ACK_INVALID;
  end

  assign acted = exec & (ack == avsrc_pkg::ACK_DONE);

  // read mux; rail 1 chosen only when bit 1 of the select is set and bit 0 is clear
  always_comb
  begin
    logic r;
    r = sel[1] & ~sel[0];
    unique case (f_cmd)
      avsrc_pkg::CMD_TARGET: rd_data = tgt_reg[r];
      avsrc_pkg::CMD_SLEW: rd_data = slew_reg[r];
      avsrc_pkg::CMD_CURRENT: rd_data = rail_current_i[r];
      avsrc_pkg::CMD_TEMP: rd_data = temperature_i[r];
      avsrc_pkg::CMD_STATUS:
      begin
        rd_data = 16'h0000;
        rd_data[avsrc_pkg::STAT_VOLTAGE_REACHED_POS] = voltage_reached_i[r];
        rd_data[avsrc_pkg::STAT_OTW_POS] = ot_seen_reg[r];
      end
      avsrc_pkg::CMD_VERSION: rd_data = avsrc_pkg::VERSION_VALUE;
      default: rd_data = avsrc_pkg::DATA_ALL_ONES;
    endcase
  end

  // status summary for the addressed rails
  assign stat_resp = {&(voltage_reached_i | ~sel),
                      |(ot_seen_reg & sel),
                      avs_control_en_i,
                      2'b00};

  assign resp_body = {ack, 1'b0, stat_resp,
                      (is_write || ack != avsrc_pkg::ACK_DONE) ? avsrc_pkg::DATA_ALL_ONES
                        : rd_data,
                      avsrc_pkg::RESP_UNUSED};

  avsrc_crc3 u_tx_crc (
    .body_i(resp_body),
    .crc_o(tx_crc)
  );

  // ************************************************************
  // link framing state machine
  // ************************************************************
  // sample on link rising edges, launch reply bits on falling edges
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    rx_next = rx_reg;
    tx_next = tx_reg;
    sdata_next = sdata_reg;
    unique case (st_reg)
      ST_IDLE:
      begin
        sdata_next = ~alert_reg;
        if (rise && !md_s)
        begin
          rx_next = {rx_reg[30:0], md_s};
          cnt_next = 6'h01;
          st_next = ST_CMD;
        end
      end
      ST_CMD:
      begin
        if (rise)
        begin
          rx_next = {rx_reg[30:0], md_s};
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == 6'(avsrc_pkg::FRAME_BITS - 1))
            st_next = ST_EVAL;
        end
      end
      ST_EVAL:
      begin
        tx_next = {resp_body, tx_crc};
        sdata_next = resp_body[28];
        cnt_next = avsrc_pkg::RST_COUNT;
        st_next = ST_RESP;
      end
      ST_RESP:
      begin
        if (fall && cnt_reg != 6'h00)
        begin
          tx_next = {tx_reg[30:0], 1'b1};
          sdata_next = tx_reg[30];
        end
        if (rise)
        begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == 6'(avsrc_pkg::FRAME_BITS - 1))
            st_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg <= ST_IDLE;
      cnt_reg <= avsrc_pkg::RST_COUNT;
      rx_reg <= 32'hffffffff;
      tx_reg <= 32'hffffffff;
      sdata_reg <= 1'b1;
      clk_d_reg <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      rx_reg <= rx_next;
      tx_reg <= tx_next;
      sdata_reg <= sdata_next;
      clk_d_reg <= clk_s;
    end
  end

  // ************************************************************
  // rail target and slew registers
  // ************************************************************
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if ($signed(v) < $signed(lo))
      clamp = lo;
    else if ($signed(v) > $signed(hi))
      clamp = hi;
    else
      clamp = v;
  endfunction : clamp

  // while control is not selected the target tracks the pmbus command
  always_comb
  begin
    tgt_next = tgt_reg;
    slew_next = slew_reg;
    for (int r = 0; r < 2; r++)
    begin
      if (!init_reg)
        slew_next[r] = slew_init_i;
      if (!avs_control_en_i)
        tgt_next[r] = clamp(vout_command_i[r], vout_min_i[r], vout_max_i[r]);
      else if (acted && is_write && sel[r])
      begin
        if (f_cmd == avsrc_pkg::CMD_TARGET)
          tgt_next[r] = clamp(f_data, vout_min_i[r], vout_max_i[r]);
        else if (f_cmd == avsrc_pkg::CMD_SLEW)
          slew_next[r] = f_data;
        else if (f_cmd == avsrc_pkg::CMD_VRESET)
          tgt_next[r] = clamp(vout_command_i[r], vout_min_i[r], vout_max_i[r]);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tgt_reg <= {2{avsrc_pkg::RST_TARGET}};
      slew_reg <= {2{avsrc_pkg::RST_SLEW}};
      init_reg <= 1'b0;
    end
    else
    begin
      tgt_reg <= tgt_next;
      slew_reg <= slew_next;
      init_reg <= 1'b1;
    end
  end

  // ************************************************************
  // status flags and alert
  // ************************************************************
  // a new event in the clearing cycle survives the clear
  assign any_rise = |(voltage_reached_i & ~vr_d_reg) | |(overtemp_warning_i & ~ot_d_reg);

  always_comb
  begin
    ot_seen_next = ot_seen_reg | overtemp_warning_i;
    alert_next = alert_reg | any_rise;
    if (acted && f_cmd == avsrc_pkg::CMD_STATUS)
    begin
      alert_next = any_rise;
      if (is_write)
        ot_seen_next = (ot_seen_reg & ~sel) | overtemp_warning_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      vr_d_reg <= 2'b00;
      ot_d_reg <= 2'b00;
      ot_seen_reg <= 2'b00;
      alert_reg <= 1'b0;
    end
    else
    begin
      vr_d_reg <= voltage_reached_i;
      ot_d_reg <= overtemp_warning_i;
      ot_seen_reg <= ot_seen_next;
      alert_reg <= alert_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign avs_sdata_o = sdata_reg;
  assign target_voltage_o = tgt_reg;
  assign rail_slew_rates_o = slew_reg;

endmodule : avsrc_slave

// *** src/avsrc_pkg.sv ***
// Purpose: shared constants for the adaptive voltage serial slave and its rail registers
// Assumes: one 10 MHz system clock, link clock sampled as a plain input
// Notes: frame fields are numbered from the first bit on the wire (bit 31) down to 0
package avsrc_pkg;

  // ************************************************************
  // frame layout
  // ************************************************************
  localparam int FRAME_BITS = 32;
  localparam int CRC_BITS = 3;
  localparam int BODY_BITS = 29;
  localparam int START_HI = 31;
  localparam int RW_HI = 29;
  localparam int TYPE_POS = 27;
  localparam int CMD_HI = 26;
  localparam int RAIL_HI = 22;
  localparam int DATA_HI = 18;
  localparam int CRC_HI = 2;

  localparam logic [1:0] START_CODE = 2'h1;
  localparam logic [1:0] RW_WRITE = 2'h0;
  localparam logic [1:0] RW_READ = 2'h3;
  localparam logic CMD_TYPE_STD = 1'h0;

  // ************************************************************
  // command and rail codes
  // ************************************************************
  localparam logic [3:0] CMD_TARGET = 4'h0;
  localparam logic [3:0] CMD_SLEW = 4'h1;
  localparam logic [3:0] CMD_CURRENT = 4'h2;
  localparam logic [3:0] CMD_TEMP = 4'h3;
  localparam logic [3:0] CMD_VRESET = 4'h4;
  localparam logic [3:0] CMD_STATUS = 4'he;
  localparam logic [3:0] CMD_VERSION = 4'hf;

  localparam logic [3:0] RAIL_0 = 4'h0;
  localparam logic [3:0] RAIL_1 = 4'h1;
  localparam logic [3:0] RAIL_ALL = 4'hf;

  // ************************************************************
  // response fields
  // ************************************************************
  localparam logic [1:0] ACK_DONE = 2'h0;
  localparam logic [1:0] ACK_NO_ACTION = 2'h1;
  localparam logic [1:0] ACK_BAD_CRC = 2'h2;
  localparam logic [1:0] ACK_INVALID = 2'h3;
  localparam logic [4:0] RESP_UNUSED = 5'h1f;
  localparam logic [15:0] DATA_ALL_ONES = 16'hffff;
  localparam logic [15:0] VRESET_DATA = 16'h0000;
  localparam logic [15:0] VERSION_VALUE = 16'h0000;

  // status word bit positions
  localparam int STAT_VOLTAGE_REACHED_POS = 15;
  localparam int STAT_OTW_POS = 12;

  // ************************************************************
  // crc and reset values
  // ************************************************************
  localparam logic [2:0] CRC_SEED = 3'h0;
  localparam logic [2:0] CRC_POLY = 3'h3;
  localparam logic [15:0] RST_TARGET = 16'h0000;
  localparam logic [15:0] RST_SLEW = 16'h0000;
  localparam logic [5:0] RST_COUNT = 6'h00;

  // ************************************************************
  // link timing
  // ************************************************************
  localparam int LINK_MAX_HZ = 50000000;
  localparam int SYS_HZ = 10000000;
  localparam int SYS_PERIOD_NS = 100;

endpackage : avsrc_pkg

// *** src/avsrc_sync.sv ***
// Purpose: two flip-flop synchroniser for link pins
// Assumes: inputs are asynchronous to sys_clk_i
// Notes: only the second stage leaves this module
`timescale 1ns/100ps
module avsrc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // idle data line sits high, so reset to ones avoids a false start bit
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule : avsrc_sync

// *** src/avsrc_crc3.sv ***
// Purpose: 3-bit frame check over the 29 leading bits of a subframe
// Assumes: bit 28 of body_i is the first bit on the wire
// Notes: purely combinational, shared by receive check and transmit build
`timescale 1ns/100ps
module avsrc_crc3 (
  input wire logic [avsrc_pkg::BODY_BITS-1:0] body_i,
  output logic [avsrc_pkg::CRC_BITS-1:0] crc_o
);

  // serial lfsr unrolled msb first
  always_comb
  begin
    logic [2:0] c;
    logic fb;
    c = avsrc_pkg::CRC_SEED;
    fb = 1'b0;
    for (int i = avsrc_pkg::BODY_BITS - 1; i >= 0; i--)
    begin
      fb = body_i[i] ^ c[2];
      c = {c[1:0], 1'b0} ^ (fb ? avsrc_pkg::CRC_POLY : 3'h0);
    end
    crc_o = c;
  end

endmodule : avsrc_crc3

// *** tb/avsrc_slave_asserts.sv ***
// Purpose: port assertions for the serial rail slave
// Assumes: link clock idles low between frames
// Notes: bound onto avsrc_slave at the foot of this file
`timescale 1ns/100ps
module avsrc_slave_asserts (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic avs_clk_i,
  input wire logic avs_sdata_o,
  input wire logic avs_control_en_i,
  input wire logic [1:0][15:0] vout_command_i,
  input wire logic [1:0][15:0] vout_min_i,
  input wire logic [1:0][15:0] vout_max_i,
  input wire logic [15:0] slew_init_i,
  input wire logic [1:0] voltage_reached_i,
  input wire logic [1:0] overtemp_warning_i,
  input wire logic [1:0][15:0] target_voltage_o,
  input wire logic [1:0][15:0] rail_slew_rates_o
);
  // ********
  // helpers
  // ********
  logic [1:0][15:0] clamp_v;
  logic [4:0] lo_reg;
  logic [4:0] lo_next;

  // command clamped into the rail limits, signed compare
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      clamp_v[i] = vout_command_i[i];
      if ($signed(vout_command_i[i]) < $signed(vout_min_i[i]))
        clamp_v[i] = vout_min_i[i];
      if ($signed(vout_command_i[i]) > $signed(vout_max_i[i]))
        clamp_v[i] = vout_max_i[i];
    end
  end

  // cycles the link clock stood low; a long run means no frame in flight
  always_comb
    lo_next = (avs_clk_i || lo_reg == 5'h1f) ? {5{~avs_clk_i}} : lo_reg + 5'h01;

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      lo_reg <= 5'h00;
    else
      lo_reg <= lo_next;

  // ********
  // assertions
  // ********
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_follow_rail0: assert property (
    !avs_control_en_i |=> target_voltage_o[0] == $past(clamp_v[0]))
    else $error("rail 0 target not tracking command");
  a_follow_rail1: assert property (
    !avs_control_en_i |=> target_voltage_o[1] == $past(clamp_v[1]))
    else $error("rail 1 target not tracking command");
  a_range_rail0: assert property (
    $past(arst_n_i) |-> $signed(target_voltage_o[0]) >= $signed(vout_min_i[0])
    && $signed(target_voltage_o[0]) <= $signed(vout_max_i[0]))
    else $error("rail 0 target outside limits");
  a_range_rail1: assert property (
    $past(arst_n_i) |-> $signed(target_voltage_o[1]) >= $signed(vout_min_i[1])
    && $signed(target_voltage_o[1]) <= $signed(vout_max_i[1]))
    else $error("rail 1 target outside limits");
  a_slew_seed: assert property (
    $rose(arst_n_i) |=> rail_slew_rates_o == {2{$past(slew_init_i)}})
    else $error("slew words not seeded");
  a_slew_needs_ctl: assert property (
    $past(arst_n_i, 2) && $changed(rail_slew_rates_o) |-> $past(avs_control_en_i))
    else $error("slew word changed without serial control");
  a_alert_done: assert property (
    lo_reg > 5'h14 && $rose(|voltage_reached_i) |-> ##[1:3] !avs_sdata_o)
    else $error("no alert after done rose");
  a_alert_ot: assert property (
    lo_reg > 5'h14 && $rose(|overtemp_warning_i) |-> ##[1:3] !avs_sdata_o)
    else $error("no alert after warning rose");
endmodule : avsrc_slave_asserts

bind avsrc_slave avsrc_slave_asserts chk_u (.sys_clk_i, .arst_n_i, .avs_clk_i, .avs_sdata_o,
  .avs_control_en_i, .vout_command_i, .vout_min_i, .vout_max_i, .slew_init_i,
  .voltage_reached_i, .overtemp_warning_i, .target_voltage_o, .rail_slew_rates_o);

// *** tb/avsrc_master_model.sv ***
// Purpose: behavioural master for the serial voltage link
// Assumes: link clock idles low, data line idles high on a pull-up
// Notes: 800 ns bit time, far inside the top link rate
`timescale 1ns/100ps
module avsrc_master_model (
  output logic avs_clk_o,
  output logic avs_mdata_o,
  input wire logic avs_sdata_i
);
  // clock stands still and data floats high between frames
  initial
  begin
    avs_clk_o = 1'b0;
    avs_mdata_o = 1'b1;
  end

  // x^3+x+1, zero seed, first bit on the wire first
  function automatic logic [2:0] crc3(input logic [28:0] body);
    logic [2:0] c;
    logic fb;
    c = 3'h0;
    for (int i = 28; i >= 0; i--)
    begin
      fb = body[i] ^ c[2];
      c = {c[1:0], 1'b0} ^ (fb ? 3'h3 : 3'h0);
    end
    return c;
  endfunction : crc3

  // one command out, one reply back; bad inverts the check bits
  task automatic frame(input logic [28:0] body, input bit bad, output logic [31:0] rep);
    logic [31:0] f;
    f = {body, crc3(body) ^ {3{bad}}};
    #13;
    for (int i = 31; i >= 0; i--)
    begin
      avs_clk_o = 1'b0;
      avs_mdata_o = f[i];
      #400;
      avs_clk_o = 1'b1;
      #400;
    end
    avs_mdata_o = 1'b1; // released, pull-up wins
    for (int i = 31; i >= 0; i--)
    begin
      avs_clk_o = 1'b0;
      #400;
      rep[i] = avs_sdata_i; // taken at the rising edge, before the slave moves
      avs_clk_o = 1'b1;
      #400;
    end
    avs_clk_o = 1'b0;
    #400;
  endtask : frame
endmodule : avsrc_master_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the serial rail slave
// Assumes: master model drives the link at 800 ns a bit
// Notes: expected replies come from a register model kept here
`timescale 1ns/100ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic arst_n_i;
  logic avs_clk_i;
  logic avs_mdata_i;
  logic avs_sdata_o;
  logic avs_control_en_i;
  logic [1:0][15:0] vout_command_i;
  logic [1:0][15:0] vout_min_i;
  logic [1:0][15:0] vout_max_i;
  logic [15:0] slew_init_i;
  logic [1:0][15:0] rail_current_i;
  logic [1:0][15:0] temperature_i;
  logic [1:0] voltage_reached_i;
  logic [1:0] overtemp_warning_i;
  logic [1:0][15:0] target_voltage_o;
  logic [1:0][15:0] rail_slew_rates_o;
  logic [1:0][15:0] tgt;
  logic [1:0][15:0] slw;
  logic [1:0] ot_seen;
  logic [3:0] rl [3] = '{4'h0, 4'h1, 4'hf};
  int num_errors = 0;
  int total_checks = 0;
  int seed = 49018;

  // ********
  // clock, design and link master
  // ********
  always #50 sys_clk_i = ~sys_clk_i;

  avsrc_slave dut_u (.sys_clk_i, .arst_n_i, .avs_clk_i, .avs_mdata_i, .avs_sdata_o,
    .avs_control_en_i, .vout_command_i, .vout_min_i, .vout_max_i, .slew_init_i,
    .rail_current_i, .temperature_i, .voltage_reached_i, .overtemp_warning_i,
    .target_voltage_o, .rail_slew_rates_o);

  avsrc_master_model master_u (.avs_clk_o(avs_clk_i), .avs_mdata_o(avs_mdata_i),
    .avs_sdata_i(avs_sdata_o));

  // ********
  // checking and model
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  function automatic logic [15:0] clamp(input logic [15:0] v, input int r);
    if ($signed(v) < $signed(vout_min_i[r]))
      return vout_min_i[r];
    if ($signed(v) > $signed(vout_max_i[r]))
      return vout_max_i[r];
    return v;
  endfunction : clamp

  // one transfer; the model predicts the whole reply, then the register outputs
  task automatic xfer(input logic [1:0] rw, input logic [3:0] cmd, input logic [3:0] rail,
                      input logic [15:0] d, input bit bad);
    logic [31:0] rep;
    logic [28:0] exp;
    logic [1:0] ack;
    logic [15:0] ed;
    logic [1:0] m;
    bit is_wr;
    int r;
    is_wr = (rw == 2'h0);
    r = rail[0];
    m = {rail == 4'hf || rail == 4'h1, rail == 4'hf || rail == 4'h0};
    if (!is_wr)
      d = 16'hffff;
    if (bad)
      ack = 2'h2;
    else if ((rail > 4'h1 && rail != 4'hf) || !(cmd inside {[4'h0:4'h4], 4'he, 4'hf}))
      ack = 2'h3;
    else if (is_wr && (!avs_control_en_i || cmd inside {4'h2, 4'h3, 4'hf}))
      ack = 2'h3;
    else if (!is_wr && (cmd == 4'h4 || rail == 4'hf))
      ack = 2'h3;
    else
      ack = (is_wr && cmd == 4'h4 && d != 16'h0) ? 2'h1 : 2'h0;
    ed = 16'hffff;
    if (ack == 2'h0 && !is_wr)
      case (cmd)
        4'h0: ed = tgt[r];
        4'h1: ed = slw[r];
        4'h2: ed = rail_current_i[r];
        4'h3: ed = temperature_i[r];
        4'he: ed = {voltage_reached_i[r], 2'h0, ot_seen[r], 12'h0};
        default: ed = 16'h0;
      endcase
    exp = {ack, 1'b0, &(voltage_reached_i | ~m),
           |(ot_seen & m), avs_control_en_i, 2'h0, ed, 5'h1f};
    @(negedge sys_clk_i);
    master_u.frame({2'h1, rw, 1'b0, cmd, rail, d}, bad, rep);
    check(rep, {exp, master_u.crc3(exp)});
    for (int i = 0; i < 2; i++)
      if (ack == 2'h0 && is_wr && (rail == 4'hf || r == i))
        case (cmd)
          4'h0: tgt[i] = clamp(d, i);
          4'h1: slw[i] = d;
          4'h4: tgt[i] = clamp(vout_command_i[i], i);
          default: ;
        endcase
    check(target_voltage_o, tgt);
    check(rail_slew_rates_o, slw);
  endtask : xfer

  // ********
  // tests
  // ********
  initial
  begin
    arst_n_i = 1'b0;
    avs_control_en_i = 1'b0;
    vout_command_i = {16'h0500, 16'h0384};
    vout_min_i = {16'hff38, 16'h0258};
    vout_max_i = {16'h04b0, 16'h04b0};
    slew_init_i = 16'h0a05;
    rail_current_i = $random(seed);
    temperature_i = $random(seed);
    voltage_reached_i = 2'h0;
    overtemp_warning_i = 2'h0;
    ot_seen = 2'h0;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    // control off: loaded values readable, writes refused
    tgt = {clamp(vout_command_i[1], 1), clamp(vout_command_i[0], 0)};
    slw = {2{slew_init_i}};
    xfer(2'h3, 4'h0, 4'h1, 16'h0, 1'b0);
    xfer(2'h0, 4'h0, 4'h0, 16'h0400, 1'b0);
    xfer(2'h0, 4'h1, 4'hf, 16'h0101, 1'b0);
    $display("test control-off done");
    // control on: random writes on single and broadcast rails, every code read
    @(negedge sys_clk_i);
    avs_control_en_i = 1'b1;
    vout_command_i[0] = 16'h03e8;
    for (int i = 0; i < 6; i++)
      xfer(2'h0, {3'h0, i[0]}, rl[i % 3], 16'($random(seed)), 1'b0);
    for (int i = 0; i < 2; i++)
      for (int c = 0; c < 16; c++)
        xfer(2'h3, c[3:0], i[3:0], 16'h0, 1'b0);
    xfer(2'h0, 4'h4, 4'h0, 16'h0001, 1'b0);
    xfer(2'h0, 4'h4, 4'h0, 16'h0000, 1'b0);
    xfer(2'h0, 4'h0, 4'hf, 16'h0300, 1'b1);
    xfer(2'h0, 4'h2, 4'h1, 16'h0000, 1'b0);
    xfer(2'h3, 4'h0, 4'hf, 16'h0, 1'b0);
    $display("test control-on done");
    // status: alert while idle, cleared by a status read
    repeat (30) @(negedge sys_clk_i);
    voltage_reached_i = 2'h3;
    overtemp_warning_i = 2'h1;
    ot_seen = 2'h1;
    repeat (5) @(negedge sys_clk_i);
    check(avs_sdata_o, 32'h0);
    xfer(2'h3, 4'he, 4'h0, 16'h0, 1'b0);
    check(avs_sdata_o, 32'h1);
    xfer(2'h3, 4'he, 4'h1, 16'h0, 1'b0);
    $display("test status done");
    results();
  end

  // watchdog, about twice the expected run
  initial
  begin
    #5000000;
    num_errors++;
    $display("watchdog expired");
    results();
  end
endmodule : tb_top
